// [rtl/smbus_exp_cfg.svh]
// Constants for the SMBus I/O expander bit map block.
// Assumes a 100 MHz core clock and 16-bit expanders on a shared SMBus.
`ifndef SMBUS_EXP_CFG_SVH
`define SMBUS_EXP_CFG_SVH

`define CLK_PERIOD_NS      10
// Fast link clock keeps runs short; a board wants 10000 or more
`define SMB_SCL_PERIOD_NS  125
// Least time per quarter bit, rounded up to whole cycles
`define SMB_QUARTER_CYC \
  ((`SMB_SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Seven-bit bus addresses of expanders 10 to 13
`define EXP10_ADDR         7'h20
`define EXP11_ADDR         7'h21
`define EXP12_ADDR         7'h22
`define EXP13_ADDR         7'h23

// Expander register pointers
`define EXP_REG_IN         8'h00
`define EXP_REG_OUT        8'h02
`define EXP_REG_DIR        8'h06

// Direction words, a one marks an input pin
`define EXP10_DIR          16'h00FF
`define EXP11_DIR          16'hFFFF
`define EXP_OUT_DIR        16'h0000
// Written to pins that are inputs
`define EXP_PAD_BYTE       8'hFF

`endif

// [rtl/smbus_exp_pkg.sv]
// Types shared by the expander master and its bit engine.
// Assumes the constants header is included where numbers are needed.
package smbus_exp_pkg;

  typedef enum logic [1:0] {
    C_START = 2'h0,
    C_WRITE = 2'h1,
    C_READ  = 2'h2,
    C_STOP  = 2'h3
  } smb_cmd_e;

  typedef enum logic [1:0] {
    J_CFG = 2'h0,
    J_WR  = 2'h1,
    J_RD  = 2'h2
  } job_e;

endpackage

// [rtl/smbus_cmd_if.sv]
// Byte command channel between the transaction sequencer and bit engine.
// Both ends sit on the same core clock.
`timescale 1ns/1ns
interface smbus_cmd_if;
  import smbus_exp_pkg::*;

  logic       valid;
  smb_cmd_e   cmd;
  logic [7:0] wdata;
  logic       ack_send;
  logic       ready;
  logic       done;
  logic [7:0] rdata;
  logic       ack_ok;

  modport master (output valid, cmd, wdata, ack_send,
                  input  ready, done, rdata, ack_ok);
  modport engine (input  valid, cmd, wdata, ack_send,
                  output ready, done, rdata, ack_ok);
endinterface

// [rtl/smbus_bit_engine.sv]
// SMBus master bit engine: start, stop, byte write and byte read.
// Assumes open-drain SCL and SDA pulled up outside; honours clock stretch.
`timescale 1ns/1ns
`include "smbus_exp_cfg.svh"
module smbus_bit_engine
  import smbus_exp_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  // Command channel
  smbus_cmd_if.engine cmd_if,
  // Bus pins
  input  wire logic  scl_in,
  output logic       scl_out,
  output logic       scl_oe_n_out,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe_n_out
);

  localparam logic [8:0] QMAX = 9'(`SMB_QUARTER_CYC - 1);

  logic       scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
  logic [8:0] tick_cnt_reg;
  logic       busy_reg;
  smb_cmd_e   kind_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic       ack_snd_reg;
  logic       scl_low_reg, sda_low_reg;
  logic       done_reg, ack_ok_reg;

  wire take     = cmd_if.valid && !busy_reg;
  wire tick     = busy_reg && (tick_cnt_reg == QMAX);
  wire stall    = (q_reg == 2'd2) && !scl_s_reg;
  wire step     = tick && !stall;
  wire is_bits  = (kind_reg == C_WRITE) || (kind_reg == C_READ);
  wire last_bit = (bit_reg == 4'd8);
  wire finish   = step && (q_reg == 2'd3) && (!is_bits || last_bit);
  wire sda_q0   = (kind_reg == C_STOP)  ? 1'b1 :
                  (kind_reg == C_START) ? 1'b0 :
                  (kind_reg == C_WRITE) ? (!last_bit && !sh_reg[7]) :
                  (last_bit && ack_snd_reg);

  assign cmd_if.ready  = !busy_reg;
  assign cmd_if.done   = done_reg;
  assign cmd_if.rdata  = sh_reg;
  assign cmd_if.ack_ok = ack_ok_reg;
  // Open drain: only ever pull low
  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign scl_oe_n_out  = !scl_low_reg;
  assign sda_oe_n_out  = !sda_low_reg;

  // Pin synchronisers
  always_ff @(posedge clk_in) begin
    scl_m_reg <= scl_in;
    scl_s_reg <= scl_m_reg;
    sda_m_reg <= sda_in;
    sda_s_reg <= sda_m_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || take || tick) begin
      tick_cnt_reg <= 9'h000;
    end else if (busy_reg) begin
      tick_cnt_reg <= tick_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      q_reg    <= 2'd0;
      bit_reg  <= 4'd0;
    end else begin
      done_reg <= finish;
      if (take) begin
        busy_reg <= 1'b1;
        q_reg    <= 2'd0;
        bit_reg  <= 4'd0;
      end else if (finish) begin
        busy_reg <= 1'b0;
      end else if (step) begin
        q_reg <= q_reg + 2'd1;
        if (q_reg == 2'd3) begin
          bit_reg <= bit_reg + 4'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (take) begin
      kind_reg    <= cmd_if.cmd;
      sh_reg      <= cmd_if.wdata;
      ack_snd_reg <= cmd_if.ack_send;
    end else if (step && q_reg == 2'd2 && is_bits && !last_bit) begin
      // Write shifts out and reads back, read shifts in
      sh_reg <= {sh_reg[6:0], sda_s_reg};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_ok_reg <= 1'b0;
    end else if (step && q_reg == 2'd2 && is_bits && last_bit) begin
      ack_ok_reg <= !sda_s_reg;
    end
  end

  // Both lines released in and after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (step) begin
      unique case (q_reg)
        2'd0: sda_low_reg <= sda_q0;
        2'd1: scl_low_reg <= 1'b0;
        2'd2: begin
          if (kind_reg == C_START) sda_low_reg <= 1'b1;
          if (kind_reg == C_STOP)  sda_low_reg <= 1'b0;
        end
        2'd3: if (kind_reg != C_STOP) scl_low_reg <= 1'b1;
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_done_single: assert property (done_reg |=> !done_reg)
    else $error("engine done held longer than one cycle");
  a_sda_steady_high: assert property (
    (busy_reg && is_bits && q_reg == 2'd2) |=> $stable(sda_low_reg))
    else $error("data line moved while clock high");
  a_take_goes_busy: assert property (take |=> busy_reg && q_reg == 2'd0)
    else $error("command not taken");

endmodule

// [rtl/smbus_expander_bit_map.sv]
// Switch-side master that maps interlock, partition reset, link up and
// link active signals onto expanders 10 to 13 over SMBus.
// Assumes rst_in is the switch fundamental reset; pins have pull-ups.
`timescale 1ns/1ns
`include "smbus_exp_cfg.svh"
// Notes on behaviour
// - Bits 0-7 first port, 8-15 second port
// - Expander 10 low byte: interlock state inputs
// - Expander 10 high byte: interlock drive outputs
// - Expander 11: partition fundamental reset inputs
// - Expander 12: link up status outputs
// - Expander 13: link active status outputs
// - Any output change triggers expander write
// - Untouched in reset; initialise after release
module smbus_expander_bit_map
  import smbus_exp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Values sent to expander outputs
  input  wire logic [7:0]  interlock_drive_in,
  input  wire logic [15:0] link_up_in,
  input  wire logic [15:0] link_active_in,
  // Values read from expander inputs
  output logic [7:0]       interlock_state_out,
  output logic [15:0]      partition_fund_reset_out,
  output logic [1:0]       inputs_valid_out,
  // SMBus pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out
);

  typedef enum logic [3:0] {
    T_IDLE   = 4'b0000,
    T_START  = 4'b0001,
    T_ADDR   = 4'b0011,
    T_REG    = 4'b0010,
    T_WLO    = 4'b0110,
    T_WHI    = 4'b0111,
    T_STOP   = 4'b0101,
    T_RSTART = 4'b1010,
    T_RADDR  = 4'b1011,
    T_RLO    = 4'b1001,
    T_RHI    = 4'b1000
  } top_state_e;

  function automatic logic [6:0] exp_addr(input logic [1:0] idx);
    unique case (idx)
      2'd0: exp_addr = `EXP10_ADDR;
      2'd1: exp_addr = `EXP11_ADDR;
      2'd2: exp_addr = `EXP12_ADDR;
      2'd3: exp_addr = `EXP13_ADDR;
    endcase
  endfunction

  function automatic logic [1:0] first_set(input logic [3:0] v);
    first_set = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
  endfunction

  smbus_cmd_if x ();

  top_state_e  state_reg, state_next;
  logic        wait_reg;
  job_e        job_kind_reg;
  logic [1:0]  job_idx_reg;
  logic [15:0] job_word_reg;
  logic        fail_reg;
  logic [7:0]  rd_lo_reg, rd_hi_reg;
  logic [3:0]  cfg_done_reg, wr_valid_reg;
  logic        rd_sel_reg;
  logic [15:0] sent_reg [0:3];
  logic [15:0] out_word [0:3];
  logic [15:0] dir_word [0:3];
  logic [3:0]  wr_pend;

  // Expander output words, pin n of port p is bit 8p+n
  assign out_word[0] = {interlock_drive_in, `EXP_PAD_BYTE};
  assign out_word[1] = 16'hFFFF;
  assign out_word[2] = ~link_up_in;
  assign out_word[3] = ~link_active_in;
  assign dir_word[0] = `EXP10_DIR;
  assign dir_word[1] = `EXP11_DIR;
  assign dir_word[2] = `EXP_OUT_DIR;
  assign dir_word[3] = `EXP_OUT_DIR;

  // Last value actually sent, compared to catch every change
  for (genvar g = 0; g < 4; g++) begin : g_exp
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        sent_reg[g] <= 16'h0000;
      end else if (x.done && state_reg == T_STOP && !fail_reg &&
                   job_kind_reg == J_WR && job_idx_reg == 2'(g)) begin
        sent_reg[g] <= job_word_reg;
      end
    end
    assign wr_pend[g] = (g != 1) && (!wr_valid_reg[g] ||
                        sent_reg[g] != out_word[g]);
  end

  // Outputs first, then directions, then input polling
  wire [3:0] cfg_need = ~cfg_done_reg;
  wire       any_wr   = |wr_pend;
  wire       any_cfg  = |cfg_need;
  wire job_e nxt_kind = any_wr ? J_WR : any_cfg ? J_CFG : J_RD;
  wire [1:0] nxt_idx  = any_wr  ? first_set(wr_pend)  :
                        any_cfg ? first_set(cfg_need) : {1'b0, rd_sel_reg};
  wire [15:0] nxt_word = (nxt_kind == J_WR)  ? out_word[nxt_idx] :
                         (nxt_kind == J_CFG) ? dir_word[nxt_idx] : 16'h0000;
  wire [7:0] reg_ptr   = (job_kind_reg == J_WR)  ? `EXP_REG_OUT :
                         (job_kind_reg == J_CFG) ? `EXP_REG_DIR : `EXP_REG_IN;
  wire need_ack = (state_reg == T_ADDR) || (state_reg == T_REG) ||
                  (state_reg == T_WLO) || (state_reg == T_WHI) ||
                  (state_reg == T_RADDR);
  wire nack     = x.done && need_ack && !x.ack_ok;
  wire commit   = x.done && (state_reg == T_STOP) && !fail_reg;

  // Command decode
  assign x.valid    = (state_reg != T_IDLE) && !wait_reg;
  assign x.cmd      = (state_reg == T_START || state_reg == T_RSTART) ?
                      C_START :
                      (state_reg == T_STOP) ? C_STOP :
                      (state_reg == T_RLO || state_reg == T_RHI) ? C_READ :
                      C_WRITE;
  assign x.wdata    = (state_reg == T_ADDR)  ? {exp_addr(job_idx_reg), 1'b0} :
                      (state_reg == T_RADDR) ? {exp_addr(job_idx_reg), 1'b1} :
                      (state_reg == T_REG)   ? reg_ptr :
                      (state_reg == T_WLO)   ? job_word_reg[7:0] :
                      job_word_reg[15:8];
  assign x.ack_send = (state_reg == T_RLO); // Last byte is NACKed

  always_comb begin
    state_next = state_reg;
    if (state_reg == T_IDLE) begin
      state_next = T_START;
    end else if (x.done) begin
      unique case (state_reg)
        T_START:  state_next = T_ADDR;
        T_ADDR:   state_next = x.ack_ok ? T_REG : T_STOP;
        T_REG:    state_next = !x.ack_ok ? T_STOP :
                              (job_kind_reg == J_RD) ? T_RSTART : T_WLO;
        T_WLO:    state_next = x.ack_ok ? T_WHI : T_STOP;
        T_WHI:    state_next = T_STOP;
        T_RSTART: state_next = T_RADDR;
        T_RADDR:  state_next = x.ack_ok ? T_RLO : T_STOP;
        T_RLO:    state_next = T_RHI;
        T_RHI:    state_next = T_STOP;
        T_STOP:   state_next = T_IDLE;
        default:  state_next = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= T_IDLE;
      wait_reg  <= 1'b0;
      fail_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= (x.valid && x.ready) || (wait_reg && !x.done);
      if (state_reg == T_IDLE) fail_reg <= 1'b0;
      else if (nack)           fail_reg <= 1'b1;
    end
  end

  // Job is latched whole, so a mid-write change is caught next round
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      job_kind_reg <= J_WR;
      job_idx_reg  <= 2'd0;
      job_word_reg <= 16'h0000;
    end else if (state_reg == T_IDLE) begin
      job_kind_reg <= nxt_kind;
      job_idx_reg  <= nxt_idx;
      job_word_reg <= nxt_word;
    end
  end

  always_ff @(posedge clk_in) begin
    if (x.done && state_reg == T_RLO) rd_lo_reg <= x.rdata;
    if (x.done && state_reg == T_RHI) rd_hi_reg <= x.rdata;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_done_reg <= 4'h0;
      wr_valid_reg <= 4'h0;
      rd_sel_reg   <= 1'b0;
    end else if (commit) begin
      if (job_kind_reg == J_CFG) cfg_done_reg[job_idx_reg] <= 1'b1;
      if (job_kind_reg == J_WR)  wr_valid_reg[job_idx_reg] <= 1'b1;
    end
    if (!rst_in && x.done && state_reg == T_STOP && job_kind_reg == J_RD) begin
      rd_sel_reg <= !rd_sel_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      interlock_state_out      <= 8'h00;
      partition_fund_reset_out <= 16'h0000;
      inputs_valid_out         <= 2'h0;
    end else if (commit && job_kind_reg == J_RD) begin
      if (job_idx_reg == 2'd0) begin
        interlock_state_out <= rd_lo_reg;
        inputs_valid_out[0] <= 1'b1;
      end else begin
        partition_fund_reset_out <= ~{rd_hi_reg, rd_lo_reg};
        inputs_valid_out[1]      <= 1'b1;
      end
    end
  end

  smbus_bit_engine u_engine (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .cmd_if       (x),
    .scl_in       (scl_in),
    .scl_out      (scl_out),
    .scl_oe_n_out (scl_oe_n_out),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out)
  );

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_init_after_reset: assert property (
    $fell(rst_in) |-> state_reg == T_IDLE ##1
      (state_reg == T_START && job_kind_reg == J_WR && job_idx_reg == 2'd0))
    else $error("expander init did not start after reset");
  a_byte_order: assert property (
    (state_reg == T_WLO && x.done && x.ack_ok) |=> state_reg == T_WHI)
    else $error("second port byte not sent after first");
  a_interlock_word: assert property (
    (state_reg == T_IDLE && nxt_kind == J_WR && nxt_idx == 2'd0) |=>
      job_word_reg[15:8] == $past(interlock_drive_in))
    else $error("interlock drive not in high byte");
  a_link_up_word: assert property (
    (state_reg == T_IDLE && nxt_kind == J_WR && nxt_idx == 2'd2) |=>
      job_word_reg == ~$past(link_up_in))
    else $error("link up word wrong");
  a_link_active_word: assert property (
    (state_reg == T_IDLE && nxt_kind == J_WR && nxt_idx == 2'd3) |=>
      job_word_reg == ~$past(link_active_in))
    else $error("link active word wrong");
  a_change_writes: assert property (
    (state_reg == T_IDLE && wr_pend[2] && !wr_pend[0]) |=>
      job_kind_reg == J_WR && job_idx_reg == 2'd2)
    else $error("changed output not written");
  a_interlock_read: assert property (
    (commit && job_kind_reg == J_RD && job_idx_reg == 2'd0) |=>
      interlock_state_out == $past(rd_lo_reg) && inputs_valid_out[0])
    else $error("interlock state not presented");
  a_partition_read: assert property (
    (commit && job_kind_reg == J_RD && job_idx_reg == 2'd1) |=>
      partition_fund_reset_out[7:0] == ~$past(rd_lo_reg) &&
      partition_fund_reset_out[15:8] == ~$past(rd_hi_reg))
    else $error("partition reset word not presented");
  a_partition_dir: assert property (
    (state_reg == T_IDLE && nxt_kind == J_CFG && nxt_idx == 2'd1) |=>
      job_word_reg == 16'hFFFF)
    else $error("expander 11 not set all inputs");
  a_read_nack_last: assert property (
    (state_reg == T_RHI && x.valid) |-> !x.ack_send && x.cmd == C_READ)
    else $error("last read byte not NACKed");

endmodule

// [dv/exp_model.sv]
// Behavioural SMBus 16-bit I/O expanders 10 to 13, one shared bus.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ns
`include "smbus_exp_cfg.svh"
module exp_model (
  // Bus wires
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // Pin levels and options
  input  wire logic        stretch_in,
  input  wire logic [7:0]  pins10_in,
  input  wire logic [15:0] pins11_in,
  // Pulls and register view
  output logic             scl_oe_n_out,
  output logic             sda_oe_n_out,
  output logic [15:0]      out_word_out [4],
  output logic [15:0]      dir_word_out [4]
);
  logic        started;
  logic        nack;
  logic [1:0]  idx;
  logic [7:0]  adr;
  logic [7:0]  ptr;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [15:0] rd_word;
  // Power-up state: all pins inputs, output latches high
  initial begin
    started      = 1'b0;
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
    for (int i = 0; i < 4; i++) begin
      out_word_out[i] = 16'hFFFF;
      dir_word_out[i] = 16'hFFFF;
    end
  end
  task automatic rx_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl_in);
      v[i] = sda_in;
    end
    @(negedge scl_in);
  endtask
  // Hold past the falling edge, then optionally stretch the low phase
  // Stretch only after a byte received in a write, so no sent bit moves with SCL
  task automatic ack_bit(input logic hold);
    #13 sda_oe_n_out = 1'b0;
    @(posedge scl_in);
    @(negedge scl_in);
    #13 sda_oe_n_out = 1'b1;
    if (stretch_in && hold) begin
      scl_oe_n_out = 1'b0;
      #200 scl_oe_n_out = 1'b1;
    end
  endtask
  task automatic tx_byte(input logic [7:0] v, output logic nk);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_n_out = v[i];
      @(posedge scl_in);
      @(negedge scl_in);
      #13;
    end
    sda_oe_n_out = 1'b1;
    @(posedge scl_in);
    nk = sda_in;
    @(negedge scl_in);
  endtask
  always begin : run
    wait (started === 1'b1);
    started = 1'b0;
    rx_byte(adr);
    idx = 2'(adr[7:1] - `EXP10_ADDR);
    if (adr[7:1] >= `EXP10_ADDR && adr[7:1] <= `EXP13_ADDR) begin
      ack_bit(!adr[0]);
      if (adr[0]) begin
        rd_word = (idx == 2'h0) ? {out_word_out[0][15:8], pins10_in}
                                : pins11_in;
        tx_byte(rd_word[7:0], nack);
        if (!nack) tx_byte(rd_word[15:8], nack);
      end else begin
        rx_byte(ptr);
        ack_bit(1'b1);
        rx_byte(lo);
        ack_bit(1'b1);
        rx_byte(hi);
        ack_bit(1'b1);
        if (ptr == `EXP_REG_OUT) out_word_out[idx] = {hi, lo};
        if (ptr == `EXP_REG_DIR) dir_word_out[idx] = {hi, lo};
      end
    end
  end
  // Start or stop resynchronises, as a real slave does
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    disable run;
    sda_oe_n_out = 1'b1;
    started      = 1'b1;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) begin
    disable run;
    sda_oe_n_out = 1'b1;
    scl_oe_n_out = 1'b1;
    started      = 1'b0;
  end
endmodule

// [dv/smbus_expander_bit_map_bench.sv]
// Self-checking bench for the expander bit map master.
// Assumes pull-ups on both wires and the expander model as far side.
`timescale 1ns/1ns
`include "smbus_exp_cfg.svh"
module smbus_expander_bit_map_bench;
  logic        clk_in;
  logic        rst_in;
  logic [7:0]  interlock_drive_in;
  logic [15:0] link_up_in;
  logic [15:0] link_active_in;
  logic [7:0]  interlock_state_out;
  logic [15:0] partition_fund_reset_out;
  logic [1:0]  inputs_valid_out;
  logic        scl_out;
  logic        scl_oe_n_out;
  logic        sda_out;
  logic        sda_oe_n_out;
  logic        m_scl_oe_n;
  logic        m_sda_oe_n;
  logic        stretch;
  logic [7:0]  pins10;
  logic [15:0] pins11;
  logic [15:0] out_word [4];
  logic [15:0] dir_word [4];
  wire         scl_wire;
  wire         sda_wire;
  int          n_mismatch;
  int          n_tests;
  assign scl_wire = (scl_oe_n_out | scl_out) & m_scl_oe_n;
  assign sda_wire = (sda_oe_n_out | sda_out) & m_sda_oe_n;
  smbus_expander_bit_map dut (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .interlock_drive_in       (interlock_drive_in),
    .link_up_in               (link_up_in),
    .link_active_in           (link_active_in),
    .interlock_state_out      (interlock_state_out),
    .partition_fund_reset_out (partition_fund_reset_out),
    .inputs_valid_out         (inputs_valid_out),
    .scl_in                   (scl_wire),
    .scl_out                  (scl_out),
    .scl_oe_n_out             (scl_oe_n_out),
    .sda_in                   (sda_wire),
    .sda_out                  (sda_out),
    .sda_oe_n_out             (sda_oe_n_out)
  );
  exp_model expander (
    .scl_in       (scl_wire),
    .sda_in       (sda_wire),
    .stretch_in   (stretch),
    .pins10_in    (pins10),
    .pins11_in    (pins11),
    .scl_oe_n_out (m_scl_oe_n),
    .sda_oe_n_out (m_sda_oe_n),
    .out_word_out (out_word),
    .dir_word_out (dir_word)
  );
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // 0-3 expander outputs, 4 interlock, 5 partition, 6-9 directions
  function automatic logic [15:0] pick(input int sel);
    case (sel)
      0, 1, 2, 3: return out_word[sel];
      4: return {8'h00, interlock_state_out};
      5: return partition_fund_reset_out;
      default: return dir_word[sel - 6];
    endcase
  endfunction
  // Bus jobs take several hundred cycles each, so wait with a bound
  task automatic expect_word(input int sel, input logic [15:0] exp);
    for (int n = 0; n < 20000 && pick(sel) !== exp; n++) begin
      @(posedge clk_in);
      #1;
    end
    check_word(pick(sel), exp);
  endtask
  task automatic t_reset_quiet(input logic [15:0] held);
    #1;
    check_word({14'h0000, scl_oe_n_out, sda_oe_n_out}, 16'h0003);
    check_word({14'h0000, inputs_valid_out}, 16'h0000);
    check_word(partition_fund_reset_out, 16'h0000);
    check_word(out_word[2], held);
  endtask
  task automatic t_init();
    expect_word(0, {8'hA6, `EXP_PAD_BYTE});
    expect_word(2, ~16'h1234);
    expect_word(3, ~16'hC3E1);
    expect_word(6, `EXP10_DIR);
    expect_word(7, `EXP11_DIR);
    expect_word(8, `EXP_OUT_DIR);
    expect_word(9, `EXP_OUT_DIR);
    expect_word(4, 16'h001D);
    expect_word(5, ~16'h8013);
    check_word({14'h0000, inputs_valid_out}, 16'h0003);
  endtask
  // Second change lands mid-job while the far side stretches
  task automatic t_update();
    @(posedge clk_in);
    stretch            <= 1'b1;
    link_active_in     <= 16'h43E1;
    interlock_drive_in <= 8'h26;
    pins10             <= 8'h9D;
    pins11             <= 16'h0013;
    repeat (1700) @(posedge clk_in);
    link_active_in     <= 16'h43E0;
    expect_word(3, ~16'h43E0);
    expect_word(0, {8'h26, `EXP_PAD_BYTE});
    expect_word(4, 16'h009D);
    expect_word(5, ~16'h0013);
    @(posedge clk_in);
    stretch <= 1'b0;
  endtask
  task automatic t_mid_reset();
    repeat (3000) @(posedge clk_in);
    rst_in     <= 1'b1;
    link_up_in <= 16'h0F0E;
    repeat (16) @(posedge clk_in);
    t_reset_quiet(~16'h1234);
    @(posedge clk_in);
    rst_in <= 1'b0;
    expect_word(2, ~16'h0F0E);
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    n_mismatch         = 0;
    n_tests            = 0;
    rst_in             = 1'b1;
    stretch            = 1'b0;
    interlock_drive_in = 8'hA6;
    link_up_in         = 16'h1234;
    link_active_in     = 16'hC3E1;
    pins10             = 8'h1D;
    pins11             = 16'h8013;
    repeat (16) @(posedge clk_in);
    t_reset_quiet(16'hFFFF);
    @(posedge clk_in);
    rst_in <= 1'b0;
    t_init();
    t_update();
    t_mid_reset();
    summarize();
  end
  initial begin
    repeat (50000) @(posedge clk_in);
    n_mismatch++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end
endmodule
